// File: rtl/isa_io_defines.svh
// Constants for the ISA I/O slave decoder: offsets, fields, reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ISA_IO_DEFINES_SVH
`define ISA_IO_DEFINES_SVH

// Parallel-port window, eight bytes
`define PORT_BASE     10'h378
`define WIN_MASK      10'h3f8
`define EPP_FIRST     3'h3
// Game-port select address
`define GAME_ADDR     10'h201
// IDE command block and alternate status pair
`define IDE_BASE      10'h1f0
`define IDE_MASK      10'h3f8
`define IDE_ALT       10'h3f6
`define IDE_ALT_MASK  10'h3fe
// Storage indices used by DMA cycles
`define FDC_DMA_IDX   4'hf
`define PP_DMA_IDX    4'h8
// Reset values
`define REG_RST       8'h00
`define SYNC_RST      6'h36

`endif

// File: rtl/isa_io_pkg.sv
// Types shared by the ISA I/O slave decoder files.
// Assumes nothing of its surroundings.
package isa_io_pkg;

    // Access sequencer states, one-hot
    typedef enum logic [2:0]
    {
        st_idle  = 3'b001,
        st_read  = 3'b010,
        st_write = 3'b100
    } acc_state_t;

    typedef logic [7:0] data_t;

endpackage

// File: rtl/isa_store_if.sv
// Interface between the access sequencer and the register store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface isa_store_if #(
    parameter int AW = 4,
    parameter int DW = 8
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctrl
    (
        output we,
        output waddr,
        output wdata,
        output raddr,
        input  rdata
    );

    modport store
    (
        input  we,
        input  waddr,
        input  wdata,
        input  raddr,
        output rdata
    );
endinterface

`default_nettype wire

// File: rtl/isa_reg_store.sv
// Small register store of the ISA slave with registered read data.
// Assumes write and read requests come from the sequencer on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "isa_io_defines.svh"

module isa_reg_store #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Sequencer side
    isa_store_if.store bus
);

    logic [DW-1:0] mem_q [2**AW];

    // Storage, cleared on bus reset
    // default contents
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 2**AW; i++)
                mem_q[i] <= DW'(`REG_RST);
        end
        else if (bus.we)
            mem_q[bus.waddr] <= bus.wdata;
    end

    // Registered read port
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bus.rdata <= DW'(`REG_RST);
        else
            bus.rdata <= mem_q[bus.raddr];
    end

endmodule

`default_nettype wire

// File: rtl/isa_io_slave_decoder.sv
// Eight-bit ISA I/O slave front end: decode, read drive, write capture,
// no-wait-state, channel ready stretching, DMA qualification, game select.
// Assumes rst_n_i comes from the bus reset line; address, data and function-state inputs are clk_i-synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "isa_io_defines.svh"

module isa_io_slave_decoder #(
    parameter logic [9:0] PORT_BASE = `PORT_BASE,
    parameter int         AW        = 4
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // ISA address and data
    input  wire logic [10:0] sa_i,
    input  wire logic [7:0]  sd_i,
    output logic      [7:0]  sd_o,
    output logic             sd_oe_o,
    // ISA commands and DMA
    input  wire logic        ior_n_i,
    input  wire logic        iow_n_i,
    input  wire logic        aen_i,
    input  wire logic        floppy_dma_ack_n_i,
    input  wire logic        parport_dma_ack_n_i,
    input  wire logic        tc_i,
    // Open-drain cycle control
    output logic             no_wait_o,
    output logic             no_wait_oe_o,
    output logic             chan_ready_o,
    output logic             chan_ready_oe_o,
    // Function state
    input  wire logic        epp_mode_i,
    input  wire logic        ecp_mode_i,
    input  wire logic        periph_busy_i,
    input  wire logic        hw_config_busy_i,
    input  wire logic        add_in_card_i,
    // Function selects and terminal counts
    output logic             game_cs_n_o,
    output logic             ide_sel_o,
    output logic             floppy_tc_o,
    output logic             parport_tc_o
);

    localparam logic [5:0] SYNC_RST = `SYNC_RST;

    isa_store_if #(.AW(AW), .DW(8)) store_bus ();

    logic [5:0]              async_raw;
    logic [5:0]              s1_q;
    logic [5:0]              s2_q;
    isa_io_pkg::acc_state_t  st_q;
    isa_io_pkg::acc_state_t  st_d;
    logic [AW-1:0]           addr_q;
    isa_io_pkg::data_t       wdata_q;
    logic                    rd_vld_q;
    isa_io_pkg::data_t       sd_q;
    logic                    sd_oe_q;
    logic                    nows_q;
    logic                    stall_q;
    logic                    od_low_q;
    logic                    game_n_q;
    logic                    ide_q;
    logic                    ftc_q;
    logic                    ptc_q;

    // Asynchronous inputs gathered for the synchroniser
    assign async_raw = {ior_n_i, iow_n_i, aen_i, floppy_dma_ack_n_i, parport_dma_ack_n_i, tc_i};

    // Two-flop synchroniser per input bit
    // strobe synchronisers
    for (genvar i = 0; i < 6; i++)
    begin : g_sync
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                s1_q[i] <= SYNC_RST[i];
                s2_q[i] <= SYNC_RST[i];
            end
            else
            begin
                s1_q[i] <= async_raw[i];
                s2_q[i] <= s1_q[i];
            end
        end
    end

    // Synchronised command levels
    wire rd_act  = ~s2_q[5];
    wire wr_act  = ~s2_q[4];
    wire aen_act = s2_q[3];
    wire fack    = ~s2_q[2];
    wire pack    = ~s2_q[1];
    wire tc_s    = s2_q[0];
    wire strobe  = rd_act | wr_act;

    // I/O cycles only while address enable is negated
    // address enable gating
    wire io_cyc = ~aen_act;

    // Window decode on the ten low lines, line ten for the extended set
    // ten-line decode
    wire win_hit = (sa_i[9:0] & `WIN_MASK) == PORT_BASE;
    wire ext_hit = win_hit & ecp_mode_i & sa_i[10];
    wire std_hit = win_hit & ~ext_hit;
    wire dev_hit = io_cyc & (std_hit | ext_hit);

    // IDE decode, valid but never shortened
    wire ide_hit = ((sa_i[9:0] & `IDE_MASK) == `IDE_BASE)
                 | ((sa_i[9:0] & `IDE_ALT_MASK) == `IDE_ALT);

    // DMA cycles need address enable plus an acknowledge
    // DMA cycle qualify
    wire dma_f   = aen_act & fack;
    wire dma_p   = aen_act & pack & ~fack;
    wire dma_cyc = dma_f | dma_p;
    wire acc_hit = dev_hit | dma_cyc;

    // Storage index of the access
    wire [AW-1:0] io_idx  = AW'({ext_hit, sa_i[2:0]});
    wire [AW-1:0] acc_idx = dma_f ? AW'(`FDC_DMA_IDX) : (dma_p ? AW'(`PP_DMA_IDX) : io_idx);

    // Cycle stretching conditions
    // EPP busy stretch
    wire epp_hit  = dev_hit & epp_mode_i & ~ext_hit & (sa_i[2:0] >= `EPP_FIRST);
    wire stall    = strobe & io_cyc & (hw_config_busy_i | (epp_hit & periph_busy_i));

    // Early end of a decoded, non-stalled I/O cycle
    // no-wait decode
    wire nows_d   = strobe & dev_hit & ~stall;

    // Game-port select, add-in card only
    // game select decode
    wire game_hit = add_in_card_i & io_cyc & strobe & (sa_i[9:0] == `GAME_ADDR);
    wire ide_d    = io_cyc & strobe & ide_hit;

    // Terminal count taken only under an acknowledge
    // terminal count gating
    wire ftc_d    = tc_s & fack;
    wire ptc_d    = tc_s & pack;

    // Write commits once the write strobe goes away
    // rising-edge commit
    wire commit   = (st_q == isa_io_pkg::st_write) & ~wr_act;

    // Access sequencer next state
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            isa_io_pkg::st_idle:
            begin
                if (rd_act & acc_hit & ~stall)
                    st_d = isa_io_pkg::st_read;
                else if (wr_act & acc_hit & ~stall)
                    st_d = isa_io_pkg::st_write;
            end
            isa_io_pkg::st_read:
            begin
                if (~rd_act)
                    st_d = isa_io_pkg::st_idle;
            end
            isa_io_pkg::st_write:
            begin
                if (~wr_act)
                    st_d = isa_io_pkg::st_idle;
            end
            default:
                st_d = isa_io_pkg::st_idle;
        endcase
    end

    // Sequencer state and latched access index
    // reset to defaults
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q   <= isa_io_pkg::st_idle;
            addr_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            if (st_q == isa_io_pkg::st_idle)
                addr_q <= acc_idx;
        end
    end

    // Write data follows the bus while the raw strobe is low
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wdata_q <= `REG_RST;
        else if ((st_q == isa_io_pkg::st_write) & ~iow_n_i)
            wdata_q <= sd_i;
    end

    // Store port connections
    assign store_bus.we    = commit;
    assign store_bus.waddr = addr_q;
    assign store_bus.wdata = wdata_q;
    assign store_bus.raddr = addr_q;

    isa_reg_store #(
        .AW (AW),
        .DW (8)
    ) u_store (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .bus     (store_bus)
    );

    // Read data and enable aligned to the store latency
    // read drive
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_vld_q <= 1'b0;
            sd_q     <= `REG_RST;
            sd_oe_q  <= 1'b0;
        end
        else
        begin
            rd_vld_q <= (st_q == isa_io_pkg::st_read) & rd_act;
            sd_q     <= store_bus.rdata;
            sd_oe_q  <= rd_vld_q;
        end
    end

    // Registered cycle control and selects
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nows_q   <= 1'b0;
            stall_q  <= 1'b0;
            od_low_q <= 1'b0;
            game_n_q <= 1'b1;
            ide_q    <= 1'b0;
            ftc_q    <= 1'b0;
            ptc_q    <= 1'b0;
        end
        else
        begin
            nows_q   <= nows_d;
            stall_q  <= stall;
            od_low_q <= 1'b0;
            game_n_q <= ~game_hit;
            ide_q    <= ide_d;
            ftc_q    <= ftc_d;
            ptc_q    <= ptc_d;
        end
    end

    // Outputs, open-drain pins pull low while enabled
    assign sd_o            = sd_q;
    assign sd_oe_o         = sd_oe_q;
    assign no_wait_o       = od_low_q;
    assign no_wait_oe_o    = nows_q;
    assign chan_ready_o    = od_low_q;
    assign chan_ready_oe_o = stall_q;
    assign game_cs_n_o     = game_n_q;
    assign ide_sel_o       = ide_q;
    assign floppy_tc_o     = ftc_q;
    assign parport_tc_o    = ptc_q;

    // Checks on cycle control and sequencing
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_nows_decode: assert property (
        (strobe && !aen_act && ((sa_i[9:0] & `WIN_MASK) == PORT_BASE)
            && !hw_config_busy_i && !epp_mode_i) |=> no_wait_oe_o)
        else $error("no-wait missing on decoded access");

    a_nows_excluded: assert property (
        (ide_hit || aen_act) |=> !no_wait_oe_o)
        else $error("no-wait on IDE or DMA cycle");

    a_rdy_config: assert property (
        (strobe && io_cyc && hw_config_busy_i) |=> chan_ready_oe_o && !no_wait_oe_o)
        else $error("channel ready not held during configuration");

    a_rdy_epp: assert property (
        (strobe && epp_hit && periph_busy_i) |=> chan_ready_oe_o)
        else $error("channel ready not held for busy EPP peripheral");

    a_game_select: assert property (
        !game_cs_n_o |-> $past(add_in_card_i) && (($past(sa_i) & 11'h3ff) == 11'h201))
        else $error("game select without add-in card or wrong address");

    a_tc_gated: assert property (
        (floppy_tc_o || parport_tc_o) |-> $past(tc_s) && ($past(fack) || $past(pack)))
        else $error("terminal count taken without acknowledge");

    a_write_commit: assert property (
        store_bus.we |-> $past(wr_act) && !wr_act ##1 st_q == isa_io_pkg::st_idle)
        else $error("write committed off the strobe rising edge");

    a_read_drive: assert property (
        $rose(sd_oe_o) |-> $past(st_q, 2) == isa_io_pkg::st_read)
        else $error("data driven without a read access");

    a_aen_idle: assert property (
        (st_q == isa_io_pkg::st_idle && aen_act && !fack && !pack) |=> st_q == isa_io_pkg::st_idle)
        else $error("access started while address enable without acknowledge");

    a_dma_index: assert property (
        (st_q == isa_io_pkg::st_idle && strobe && dma_f) |=> addr_q == `FDC_DMA_IDX)
        else $error("floppy DMA cycle used wrong storage index");

endmodule

`default_nettype wire

// File: tb/isa_host_model.sv
// Host CPU and DMA controller model that runs strobed cycles on the decoder.
// Assumes the decoder's outputs have settled by each falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module isa_host_model (
    // Clock
    input  wire logic        clk_i,
    // Bus pins driven by the host
    output logic      [10:0] sa_o,
    output logic      [7:0]  sd_o,
    output logic             ior_n_o,
    output logic             iow_n_o,
    output logic             aen_o,
    output logic             fack_n_o,
    output logic             pack_n_o,
    output logic             tc_o,
    // Decoder outputs watched
    input  wire logic [7:0]  rd_i,
    input  wire logic        rd_oe_i,
    input  wire logic        nws_oe_i,
    input  wire logic        rdy_oe_i,
    input  wire logic        gcs_n_i,
    input  wire logic        ide_i,
    input  wire logic        ftc_i,
    input  wire logic        ptc_i
);
    // Seen flags: nws, rdy, gcs, ide, ftc, ptc, rd_oe (bit 6 down to 0)
    logic [6:0] seen;
    logic [7:0] rdata;

    // Idle bus at time zero
    initial
    begin
        {sa_o, sd_o} = '0;
        {ior_n_o, iow_n_o, aen_o, fack_n_o, pack_n_o, tc_o} = 6'b110110;
    end

    // One strobed cycle; ctl = {aen, floppy ack_n, parport ack_n, tc}
    task automatic cycle(input logic wr, input logic [3:0] ctl, input logic [10:0] a, input logic [7:0] d);
        int n;
        int m;
        @(negedge clk_i);
        {aen_o, fack_n_o, pack_n_o, tc_o} = ctl;
        sa_o = a;
        sd_o = d;
        seen = '0;
        if (wr)
            iow_n_o = 1'b0;
        else
            ior_n_o = 1'b0;
        n = 0;
        m = 0;
        // Strobe held eight clocks past the last negated ready, so read data
        // that follows a stretched cycle is still seen; bounded at 300 clocks
        while (n < 8 && m < 300)
        begin
            @(negedge clk_i);
            n++;
            m++;
            seen |= {nws_oe_i === 1'b1, rdy_oe_i === 1'b1, gcs_n_i === 1'b0, ide_i === 1'b1,
                     ftc_i === 1'b1, ptc_i === 1'b1, rd_oe_i === 1'b1};
            if (rd_oe_i === 1'b1)
                rdata = rd_i;
            if (rdy_oe_i === 1'b1)
                n = 0;
        end
        ior_n_o = 1'b1;
        iow_n_o = 1'b1;
        // Released address and data lines show the inverse of the last value
        sd_o = ~sd_o;
        sa_o = ~sa_o;
        {aen_o, fack_n_o, pack_n_o, tc_o} = 4'h6;
        repeat (5) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the ISA I/O slave decoder.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // Control sets {aen, floppy ack_n, parport ack_n, tc}
    localparam logic [3:0] IO    = 4'h6;
    localparam logic [3:0] NOACK = 4'hf;
    localparam logic [3:0] FDMA  = 4'hb;
    localparam logic [3:0] PDMA  = 4'hd;

    logic        clk_i;
    logic        rst_n_i;
    logic [10:0] sa;
    logic [7:0]  sd_w;
    logic [7:0]  rd;
    logic        rd_oe;
    logic        ior_n;
    logic        iow_n;
    logic        aen;
    logic        fack_n;
    logic        pack_n;
    logic        tc;
    logic        nws;
    logic        nws_oe;
    logic        rdy;
    logic        rdy_oe;
    logic        epp;
    logic        ecp;
    logic        busy;
    logic        cfg;
    logic        card;
    logic        gcs_n;
    logic        ide;
    logic        ftc;
    logic        ptc;
    int          mismatches;
    int          compares;

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    isa_io_slave_decoder dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sa_i(sa), .sd_i(sd_w), .sd_o(rd), .sd_oe_o(rd_oe),
        .ior_n_i(ior_n), .iow_n_i(iow_n), .aen_i(aen), .floppy_dma_ack_n_i(fack_n),
        .parport_dma_ack_n_i(pack_n), .tc_i(tc), .no_wait_o(nws), .no_wait_oe_o(nws_oe),
        .chan_ready_o(rdy), .chan_ready_oe_o(rdy_oe), .epp_mode_i(epp), .ecp_mode_i(ecp),
        .periph_busy_i(busy), .hw_config_busy_i(cfg), .add_in_card_i(card), .game_cs_n_o(gcs_n),
        .ide_sel_o(ide), .floppy_tc_o(ftc), .parport_tc_o(ptc));

    isa_host_model host (
        .clk_i(clk_i), .sa_o(sa), .sd_o(sd_w), .ior_n_o(ior_n), .iow_n_o(iow_n), .aen_o(aen),
        .fack_n_o(fack_n), .pack_n_o(pack_n), .tc_o(tc), .rd_i(rd), .rd_oe_i(rd_oe),
        .nws_oe_i(nws_oe), .rdy_oe_i(rdy_oe), .gcs_n_i(gcs_n), .ide_i(ide), .ftc_i(ftc), .ptc_i(ptc));

    task automatic chk(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // Read with no-wait expected
    task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp);
        host.cycle(1'b0, IO, a, 8'h00);
        chk(host.rdata === exp && host.seen[6] === 1'b1 && host.seen[0] === 1'b1, "read");
    endtask

    task automatic t_reset;
        @(negedge clk_i);
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        chk({rd_oe, nws, nws_oe, rdy, rdy_oe, gcs_n, ide, ftc, ptc} === 9'h008, "reset outputs");
        rst_n_i = 1'b1;
        rd_chk(11'h378, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_rw;
        for (int i = 0; i < 8; i++)
        begin
            host.cycle(1'b1, IO, 11'h378 + 11'(i), 8'ha0 + 8'(i));
            chk(host.seen[6] === 1'b1, "write no-wait");
        end
        for (int i = 0; i < 8; i++)
            rd_chk(11'h378 + 11'(i), 8'ha0 + 8'(i));
        host.cycle(1'b1, IO, 11'h77b, 8'h11);
        rd_chk(11'h37b, 8'h11);
        ecp = 1'b1;
        host.cycle(1'b1, IO, 11'h778, 8'h3c);
        rd_chk(11'h778, 8'h3c);
        rd_chk(11'h378, 8'ha0);
        host.cycle(1'b0, IO, 11'h278, 8'h00);
        chk(host.seen[6] === 1'b0 && host.seen[0] === 1'b0, "unmapped");
        $display("test rw done");
    endtask

    task automatic t_ide;
        host.cycle(1'b0, IO, 11'h1f3, 8'h00);
        chk(host.seen[3] === 1'b1 && host.seen[6] === 1'b0, "ide block");
        host.cycle(1'b1, IO, 11'h3f7, 8'h55);
        chk(host.seen[3] === 1'b1 && host.seen[6] === 1'b0, "ide alt");
        $display("test ide done");
    endtask

    task automatic t_dma;
        host.cycle(1'b1, NOACK, 11'h379, 8'hee);
        chk(host.seen[2:1] === 2'b00 && host.seen[6] === 1'b0, "aen without ack");
        rd_chk(11'h379, 8'ha1);
        host.cycle(1'b1, FDMA, 11'h000, 8'h77);
        chk(host.seen[6] === 1'b0 && host.seen[2:1] === 2'b10, "floppy dma write");
        host.cycle(1'b0, FDMA, 11'h000, 8'h00);
        chk(host.rdata === 8'h77 && host.seen[0] === 1'b1, "floppy dma read");
        rd_chk(11'h77f, 8'h77);
        host.cycle(1'b1, PDMA, 11'h000, 8'h66);
        chk(host.seen[6] === 1'b0 && host.seen[2:1] === 2'b01, "parport dma");
        rd_chk(11'h778, 8'h66);
        ecp = 1'b0;
        $display("test dma done");
    endtask

    // Read while a stall cause is released after 30 clocks
    task automatic stall(input logic [10:0] a, input logic [7:0] exp, input logic want);
        fork
            host.cycle(1'b0, IO, a, 8'h00);
            begin
                repeat (30) @(negedge clk_i);
                cfg = 1'b0;
                busy = 1'b0;
            end
        join
        chk(host.seen[5] === want && host.rdata === exp && host.seen[0] === 1'b1, "ready stretch");
    endtask

    task automatic t_stall;
        cfg = 1'b1;
        stall(11'h37a, 8'ha2, 1'b1);
        epp = 1'b1;
        busy = 1'b1;
        stall(11'h37c, 8'ha4, 1'b1);
        busy = 1'b1;
        stall(11'h378, 8'ha0, 1'b0);
        epp = 1'b0;
        $display("test stall done");
    endtask

    task automatic t_game;
        card = 1'b1;
        host.cycle(1'b0, IO, 11'h201, 8'h00);
        chk(host.seen[4] === 1'b1, "game select");
        host.cycle(1'b0, IO, 11'h202, 8'h00);
        chk(host.seen[4] === 1'b0, "game other address");
        card = 1'b0;
        host.cycle(1'b0, IO, 11'h201, 8'h00);
        chk(host.seen[4] === 1'b0, "game on motherboard");
        $display("test game done");
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence, second reset at the end
    initial
    begin
        {rst_n_i, epp, ecp, busy, cfg, card} = '0;
        mismatches = 0;
        compares = 0;
        t_reset();
        t_rw();
        t_ide();
        t_dma();
        t_stall();
        t_game();
        t_reset();
        close_out();
    end

    // Watchdog well beyond the expected run of about 650 clocks
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        $display("[FAIL] %0t watchdog", $time);
        close_out();
    end
endmodule

`default_nettype wire
